// >>> shared/ccsw_pkg.sv
// Purpose: Shared constants and types for the CPU clock switch control.
// Assumes: One core clock; oscillators arrive as pins.
// Notes:   Latencies are counted in cycles of the old CPU clock.
package ccsw_pkg;

  // Register bit positions and values
  localparam int PROC_SEL_BIT = 1;
  localparam int PROC_STOP_BIT = 7;
  localparam int SUBC_SEL_BIT = 4;
  localparam logic [7:0] PROC_RESET = 8'h02;
  localparam logic [7:0] SUBC_RESET = 8'h00;
  localparam logic [7:0] PROC_WMASK = 8'h82;
  localparam logic [7:0] SUBC_WMASK = 8'h10;

  // Switch latencies in old-clock cycles
  localparam logic [8:0] LAT_SHORT = 9'h002;
  localparam logic [8:0] LAT_SLOW_FAST = 9'h004;
  localparam logic [8:0] LAT_X_SLOW_SUB = 9'h132;
  localparam logic [8:0] LAT_X_FAST_SUB = 9'h04C;
  localparam logic [8:0] LAT_R_SLOW_SUB = 9'h0F4;
  localparam logic [8:0] LAT_R_FAST_SUB = 9'h03D;

  // Stabilisation counts in main oscillator cycles
  localparam int STAB_XTAL = 32768;
  localparam int STAB_RC = 128;

  // Main oscillator edges per CPU cycle
  localparam int FAST_DIV = 2;
  localparam int SLOW_DIV = 4;

  // Reset values of the counters
  localparam logic [15:0] STAB_CNT_RESET = 16'h0000;
  localparam logic [8:0] LAT_CNT_RESET = 9'h000;
  localparam logic [2:0] DIV_CNT_RESET = 3'h0;

  typedef enum logic [1:0] {
    SRC_SLOW = 2'h0,
    SRC_FAST = 2'h1,
    SRC_SUB = 2'h2
  } ccsw_src_t;

  typedef enum logic [2:0] {
    ST_STAB = 3'h1,
    ST_RUN = 3'h2,
    ST_SWITCH = 3'h4
  } ccsw_state_t;

endpackage : ccsw_pkg

// >>> src/ccsw_ctrl.sv
// Purpose: CPU clock source selection, switch latency and reset wait.
// Assumes: Oscillator pins are sampled by core_clk, well above their rate.
// Notes:   cpu_tick marks one CPU clock cycle of the active source.
`timescale 1ns/1ns
// Contract
// - CPU clock chosen from speed-select bit 1 and subsystem-select bit 4.
// - After a selection change the old source keeps clocking for a delay.
// - Crystal latencies: slow-fast 4, slow-sub 306, fast-slow 2, sub-main 2.
// - RC latencies: slow-sub 244, fast-sub 61, slow-fast 4, others 2.
// - Latency counted in cycles of the CPU clock used before the switch.
// - Reset release starts main oscillator and holds CPU for 2^15 or 2^7.
// - After the wait execution begins on the slow main clock.
// - Clearing the stop bit restarts the main oscillator.
// - Reset loads the processor clock register with the slow setting.
// - On subsystem clock main may stop, but STOP mode is refused.
module ccsw_ctrl #(
  parameter bit RC_VARIANT = 1'b0,
  parameter int STAB_XTAL_CYCLES = ccsw_pkg::STAB_XTAL
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register writes from the CPU
  input wire logic proc_wr,
  input wire logic subc_wr,
  input wire logic [7:0] wr_data,
  // Oscillator pins
  input wire logic main_osc_pin,
  input wire logic sub_osc_pin,
  // Standby request
  input wire logic stop_req,
  // Register contents
  output logic [7:0] processor_clock_reg,
  output logic [7:0] subclock_control_reg,
  // Clock control outputs
  output logic main_osc_enable,
  output logic cpu_hold,
  output logic cpu_tick,
  output logic [1:0] active_src,
  output logic switch_busy,
  output logic stop_enter
);

  localparam int STAB_N = RC_VARIANT ? ccsw_pkg::STAB_RC : STAB_XTAL_CYCLES;

  function automatic logic [8:0] lat_of(input ccsw_pkg::ccsw_src_t from,
                                        input ccsw_pkg::ccsw_src_t to,
                                        input logic rc);
    logic [8:0] lat;
    lat = ccsw_pkg::LAT_SHORT;
    if (from == ccsw_pkg::SRC_SLOW && to == ccsw_pkg::SRC_FAST) begin
      lat = ccsw_pkg::LAT_SLOW_FAST;
    end else if (from == ccsw_pkg::SRC_SLOW && to == ccsw_pkg::SRC_SUB) begin
      lat = rc ? ccsw_pkg::LAT_R_SLOW_SUB : ccsw_pkg::LAT_X_SLOW_SUB;
    end else if (from == ccsw_pkg::SRC_FAST && to == ccsw_pkg::SRC_SUB) begin
      lat = rc ? ccsw_pkg::LAT_R_FAST_SUB : ccsw_pkg::LAT_X_FAST_SUB;
    end
    return lat;
  endfunction : lat_of

  logic main_tick, sub_tick;
  ccsw_pkg::ccsw_state_t state_reg, state_next;
  ccsw_pkg::ccsw_src_t active_reg, active_next, target_reg, target_next;
  ccsw_pkg::ccsw_src_t desired;
  logic [7:0] processor_clock_next, subclock_control_next;
  logic [15:0] stab_reg, stab_next;
  logic [8:0] lat_reg, lat_next, cnt_reg, cnt_next;
  logic [2:0] div_reg, div_next, div_lim;
  logic osc_en_reg, osc_en_next, tick_reg, tick_next;
  logic stop_reg, stop_next, src_tick;

  ccsw_sync_edge u_main_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pin(main_osc_pin),
    .rise(main_tick)
  );

  ccsw_sync_edge u_sub_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pin(sub_osc_pin),
    .rise(sub_tick)
  );

  always_comb begin
    processor_clock_next = processor_clock_reg;
    subclock_control_next = subclock_control_reg;
    if (proc_wr) begin
      processor_clock_next = wr_data & ccsw_pkg::PROC_WMASK;
    end
    if (subc_wr) begin
      subclock_control_next = wr_data & ccsw_pkg::SUBC_WMASK;
    end
    // Main oscillator runs whenever the stop bit is clear
    osc_en_next = ~processor_clock_next[ccsw_pkg::PROC_STOP_BIT];
  end

  always_comb begin
    if (subclock_control_reg[ccsw_pkg::SUBC_SEL_BIT]) begin
      desired = ccsw_pkg::SRC_SUB;
    end else if (processor_clock_reg[ccsw_pkg::PROC_SEL_BIT]) begin
      desired = ccsw_pkg::SRC_SLOW;
    end else begin
      desired = ccsw_pkg::SRC_FAST;
    end
    div_lim = (active_reg == ccsw_pkg::SRC_FAST) ?
              3'(ccsw_pkg::FAST_DIV) : 3'(ccsw_pkg::SLOW_DIV);
    div_next = div_reg;
    if (main_tick) begin
      div_next = (div_reg >= div_lim - 3'h1) ? 3'h0 : div_reg + 3'h1;
    end
    // Old source ticks drive the latency count
    if (active_reg == ccsw_pkg::SRC_SUB) begin
      src_tick = sub_tick;
    end else begin
      src_tick = main_tick && (div_reg >= div_lim - 3'h1);
    end
  end

  always_comb begin
    state_next = state_reg;
    active_next = active_reg;
    target_next = target_reg;
    stab_next = stab_reg;
    lat_next = lat_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ccsw_pkg::ST_STAB: begin
        active_next = ccsw_pkg::SRC_SLOW;
        if (main_tick) begin
          stab_next = stab_reg + 16'h0001;
          if (stab_reg == 16'(STAB_N - 1)) begin
            state_next = ccsw_pkg::ST_RUN;
          end
        end
      end
      ccsw_pkg::ST_RUN: begin
        if (desired != active_reg) begin
          lat_next = lat_of(active_reg, desired, RC_VARIANT);
          cnt_next = ccsw_pkg::LAT_CNT_RESET;
          target_next = desired;
          state_next = ccsw_pkg::ST_SWITCH;
        end
      end
      ccsw_pkg::ST_SWITCH: begin
        // Old source stays active until the count completes
        if (src_tick) begin
          if (cnt_reg == lat_reg - 9'h001) begin
            active_next = target_reg;
            state_next = ccsw_pkg::ST_RUN;
          end else begin
            cnt_next = cnt_reg + 9'h001;
          end
        end
      end
      default: begin
        state_next = ccsw_pkg::ST_STAB;
      end
    endcase
    tick_next = src_tick && (state_reg != ccsw_pkg::ST_STAB);
    // STOP refused while the subsystem clock drives the CPU
    stop_next = stop_req && (state_reg != ccsw_pkg::ST_STAB) &&
                (active_reg != ccsw_pkg::SRC_SUB);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      processor_clock_reg <= ccsw_pkg::PROC_RESET;
      subclock_control_reg <= ccsw_pkg::SUBC_RESET;
      osc_en_reg <= 1'b0;
      state_reg <= ccsw_pkg::ST_STAB;
      active_reg <= ccsw_pkg::SRC_SLOW;
      target_reg <= ccsw_pkg::SRC_SLOW;
      stab_reg <= ccsw_pkg::STAB_CNT_RESET;
      lat_reg <= ccsw_pkg::LAT_SHORT;
      cnt_reg <= ccsw_pkg::LAT_CNT_RESET;
      div_reg <= ccsw_pkg::DIV_CNT_RESET;
      tick_reg <= 1'b0;
      stop_reg <= 1'b0;
    end else begin
      processor_clock_reg <= processor_clock_next;
      subclock_control_reg <= subclock_control_next;
      osc_en_reg <= osc_en_next;
      state_reg <= state_next;
      active_reg <= active_next;
      target_reg <= target_next;
      stab_reg <= stab_next;
      lat_reg <= lat_next;
      cnt_reg <= cnt_next;
      div_reg <= div_next;
      tick_reg <= tick_next;
      stop_reg <= stop_next;
    end
  end

  assign main_osc_enable = osc_en_reg;
  assign cpu_hold = (state_reg == ccsw_pkg::ST_STAB);
  assign cpu_tick = tick_reg;
  assign active_src = active_reg;
  assign switch_busy = (state_reg == ccsw_pkg::ST_SWITCH);
  assign stop_enter = stop_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_switch_start;
    state_reg == ccsw_pkg::ST_RUN && desired != active_reg;
  endsequence

  sequence s_switch_end;
    state_reg == ccsw_pkg::ST_SWITCH ##1 state_reg == ccsw_pkg::ST_RUN;
  endsequence

  AST_SELECT_START: assert property (
    s_switch_start |=> state_reg == ccsw_pkg::ST_SWITCH &&
      target_reg == $past(desired))
    else $error("selection change did not start a switch");

  AST_OLD_HOLDS: assert property (
    state_reg == ccsw_pkg::ST_SWITCH ##1 state_reg == ccsw_pkg::ST_SWITCH
      |-> $stable(active_reg))
    else $error("source changed before latency expired");

  AST_X_SLOW_SUB: assert property (
    (s_switch_start and (active_reg == ccsw_pkg::SRC_SLOW &&
      desired == ccsw_pkg::SRC_SUB && !RC_VARIANT))
      |=> lat_reg == 9'h132)
    else $error("crystal slow to sub latency wrong");

  AST_R_FAST_SUB: assert property (
    (s_switch_start and (active_reg == ccsw_pkg::SRC_FAST &&
      desired == ccsw_pkg::SRC_SUB && RC_VARIANT))
      |=> lat_reg == 9'h03D)
    else $error("RC fast to sub latency wrong");

  AST_COUNT_OLD: assert property (
    s_switch_end |-> $past(src_tick) &&
      $past(cnt_reg) == $past(lat_reg) - 9'h001 &&
      active_reg == $past(target_reg))
    else $error("switch ended off the old clock count");

  AST_NO_TICK_NO_COUNT: assert property (
    (state_reg == ccsw_pkg::ST_SWITCH && !src_tick) |=>
      $stable(cnt_reg))
    else $error("latency counted without an old clock cycle");

  AST_STAB_HOLD: assert property (
    state_reg == ccsw_pkg::ST_STAB |-> cpu_hold && !cpu_tick &&
      stab_reg <= 16'(STAB_N - 1))
    else $error("CPU released during stabilisation");

  AST_START_SLOW: assert property (
    $fell(cpu_hold) |-> active_reg == ccsw_pkg::SRC_SLOW &&
      $past(stab_reg) == 16'(STAB_N - 1))
    else $error("execution did not begin on slow main clock");

  AST_RESTART: assert property (
    (proc_wr && !wr_data[ccsw_pkg::PROC_STOP_BIT]) |=> main_osc_enable)
    else $error("clearing stop bit did not restart oscillator");

  AST_NO_STOP_ON_SUB: assert property (
    stop_enter |-> $past(active_reg) != ccsw_pkg::SRC_SUB)
    else $error("STOP entered on subsystem clock");

  AST_X_FAST_SUB: assert property (
    (s_switch_start and (active_reg == ccsw_pkg::SRC_FAST &&
      desired == ccsw_pkg::SRC_SUB && !RC_VARIANT))
      |=> lat_reg == 9'h04C)
    else $error("crystal fast to sub latency wrong");

endmodule : ccsw_ctrl

// >>> src/ccsw_sync_edge.sv
// Purpose: Bring an oscillator pin into core_clk and flag its rising edges.
// Assumes: Pin toggles slower than half the core clock.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ns
module ccsw_sync_edge (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Pin and edge pulse
  input wire logic pin,
  output logic rise
);

  logic s1_reg, s2_reg, s3_reg, rise_reg;
  logic rise_next;

  always_comb begin
    rise_next = s2_reg & ~s3_reg;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      rise_reg <= rise_next;
    end
  end

  assign rise = rise_reg;

endmodule : ccsw_sync_edge

// >>> testbench/ccsw_ctrl_tb.sv
// Purpose: Self-checking bench for the CPU clock switch control.
// Assumes: Crystal variant, stabilisation count shortened to 16.
//          A second instance, RC variant, shares every input.
// Notes:   Latency is judged by CPU ticks seen until the source changes.
`timescale 1ns/1ns
module ccsw_ctrl_tb;
  localparam int STAB_N = 16;
  localparam int LIMIT = 60000;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic proc_wr = 1'b0;
  logic subc_wr = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic stop_req = 1'b0;
  logic main_osc_pin;
  logic sub_osc_pin;
  logic [7:0] proc_q;
  logic [7:0] subc_q;
  logic main_en;
  logic cpu_hold;
  logic cpu_tick;
  logic [1:0] active_src;
  logic switch_busy;
  logic stop_enter;
  logic rc_hold;
  logic rc_tick;
  logic [1:0] rc_src;
  logic rc_busy;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;

  always #50 core_clk = ~core_clk;

  ccsw_ctrl #(.RC_VARIANT(1'b0), .STAB_XTAL_CYCLES(STAB_N)) uut (
    .core_clk(core_clk), .reset(reset), .proc_wr(proc_wr), .subc_wr(subc_wr),
    .wr_data(wr_data), .main_osc_pin(main_osc_pin),
    .sub_osc_pin(sub_osc_pin), .stop_req(stop_req),
    .processor_clock_reg(proc_q), .subclock_control_reg(subc_q),
    .main_osc_enable(main_en), .cpu_hold(cpu_hold), .cpu_tick(cpu_tick),
    .active_src(active_src), .switch_busy(switch_busy),
    .stop_enter(stop_enter)
  );

  // RC variant sees the same writes; its hold, busy flag, source and latencies are judged
  ccsw_ctrl #(.RC_VARIANT(1'b1)) uut_rc (
    .core_clk(core_clk), .reset(reset), .proc_wr(proc_wr),
    .subc_wr(subc_wr), .wr_data(wr_data), .main_osc_pin(main_osc_pin),
    .sub_osc_pin(sub_osc_pin), .stop_req(stop_req),
    .processor_clock_reg(), .subclock_control_reg(),
    .main_osc_enable(), .cpu_hold(rc_hold), .cpu_tick(rc_tick),
    .active_src(rc_src), .switch_busy(rc_busy), .stop_enter()
  );

  ccsw_osc_model #(.MAIN_HALF(300), .SUB_HALF(2000)) osc (
    .main_osc_enable(main_en), .main_osc_pin(main_osc_pin),
    .sub_osc_pin(sub_osc_pin)
  );

  task check(input string what, input logic [15:0] seen,
             input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // One-cycle write strobe; registers are settled at the return
  task wr(input logic to_css, input logic [7:0] d);
    @(negedge core_clk);
    proc_wr <= !to_css;
    subc_wr <= to_css;
    wr_data <= d;
    @(negedge core_clk);
    proc_wr <= 1'b0;
    subc_wr <= 1'b0;
  endtask : wr

  // A tick seen while the switch is being taken may add one to the count
  task sw(input string what, input logic to_css, input logic [7:0] d,
          input logic [1:0] src, input int n);
    logic [1:0] old;
    logic in_range;
    int ticks;
    int k;
    old = active_src;
    ticks = 0;
    wr(to_css, d);
    check({what, " old src"}, 16'(active_src), 16'(old));
    for (k = 0; k < 20000 && active_src !== src; k++) begin
      @(negedge core_clk);
      if (cpu_tick === 1'b1)
        ticks++;
    end
    check({what, " src"}, 16'(active_src), 16'(src));
    in_range = ticks >= n && ticks <= n + 1;
    check({what, " ticks"}, 16'(in_range), 16'h0001);
    $display("test %s done", what);
  endtask : sw

  task test_reset;
    int k;
    @(negedge core_clk);
    check("main enable", 16'(main_en), 16'h0001);
    check("hold", 16'(cpu_hold), 16'h0001);
    check("proc reg reset", 16'(proc_q), 16'h0002);
    check("subclock reg reset", 16'(subc_q), 16'h0000);
    repeat (80) @(negedge core_clk);
    check("hold early", 16'(cpu_hold), 16'h0001);
    for (k = 0; k < 100 && cpu_hold !== 1'b0; k++)
      @(negedge core_clk);
    check("hold end", 16'(cpu_hold), 16'h0000);
    check("start src", 16'(active_src), 16'h0000);
    $display("test reset done");
  endtask : test_reset

  task test_switches;
    sw("slow to fast", 1'b0, 8'h00, 2'h1, 4);
    sw("fast to slow", 1'b0, 8'h02, 2'h0, 2);
    // Subsystem has run since time zero, so it is stable here
    sw("slow to sub", 1'b1, 8'hFF, 2'h2, 306);
    check("subclock reg mask", 16'(subc_q), 16'h0010);
    sw("sub to slow", 1'b1, 8'h00, 2'h0, 2);
    sw("slow to fast again", 1'b0, 8'h00, 2'h1, 4);
    sw("fast to sub", 1'b1, 8'h10, 2'h2, 76);
  endtask : test_switches

  task test_main_stop;
    wr(1'b0, 8'hFF);
    check("proc reg mask", 16'(proc_q), 16'h0082);
    check("main stopped", 16'(main_en), 16'h0000);
    stop_req <= 1'b1;
    repeat (3) @(negedge core_clk);
    check("stop on sub", 16'(stop_enter), 16'h0000);
    check("still sub", 16'(active_src), 16'h0002);
    stop_req <= 1'b0;
    wr(1'b0, 8'h00);
    check("main restart", 16'(main_en), 16'h0001);
    // Software waits out the restart itself
    repeat (STAB_N * 6 + 20) @(negedge core_clk);
    sw("sub to fast", 1'b1, 8'h00, 2'h1, 2);
    stop_req <= 1'b1;
    repeat (3) @(negedge core_clk);
    check("stop on main", 16'(stop_enter), 16'h0001);
    stop_req <= 1'b0;
    $display("test main stop done");
  endtask : test_main_stop

  // Subsystem-select write judged on the RC instance's own ticks
  task rc_sw(input string what, input logic [7:0] d,
             input logic [1:0] src, input int n);
    logic in_range;
    int ticks;
    int k;
    ticks = 0;
    wr(1'b1, d);
    for (k = 0; k < 20000 && rc_src !== src; k++) begin
      @(negedge core_clk);
      if (rc_tick === 1'b1)
        ticks++;
    end
    check({what, " src"}, 16'(rc_src), 16'(src));
    in_range = ticks >= n && ticks <= n + 1;
    check({what, " ticks"}, 16'(in_range), 16'h0001);
  endtask : rc_sw

  // Crystal instance follows along; its own slow-sub and fast-sub latencies are longer
  task test_rc;
    check("rc hold", 16'(rc_hold), 16'h0000);
    check("rc start src", 16'(rc_src), 16'h0001);
    check("rc busy", 16'(rc_busy), 16'h0000);
    rc_sw("rc fast to sub", 8'h10, 2'h2, 61);
    wr(1'b0, 8'h02);
    rc_sw("rc sub to slow", 8'h00, 2'h0, 2);
    rc_sw("rc slow to sub", 8'h10, 2'h2, 244);
    $display("test rc done");
  endtask : test_rc

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      bad_count++;
      give_verdict;
    end
  end

  initial begin
    repeat (20) @(negedge core_clk);
    reset <= 1'b0;
    test_reset;
    test_switches;
    test_main_stop;
    test_rc;
    give_verdict;
  end
endmodule : ccsw_ctrl_tb

// >>> testbench/ccsw_osc_model.sv
// Purpose: Oscillator pins for the CPU clock switch control.
// Assumes: Main half period 300 ns, subsystem half period 2000 ns.
// Notes:   Subsystem runs free from time zero, so it is stable early.
`timescale 1ns/1ns
module ccsw_osc_model #(
  parameter int MAIN_HALF = 300,
  parameter int SUB_HALF = 2000
) (
  // Enable from the block
  input wire logic main_osc_enable,
  // Oscillator waveforms
  output logic main_osc_pin,
  output logic sub_osc_pin
);
  initial main_osc_pin = 1'b0;
  initial sub_osc_pin = 1'b0;

  // Stopped main oscillator stands still low, as a dead resonator would
  always begin
    #(MAIN_HALF);
    main_osc_pin = main_osc_enable ? ~main_osc_pin : 1'b0;
  end

  always #(SUB_HALF) sub_osc_pin = ~sub_osc_pin;
endmodule : ccsw_osc_model
